// [design/bbcc_defines.vh]
// Constants for the battery backed calendar clock: the clock register map, field positions,
// reset values and timing counts.
// Assumes a 20 MHz core clock and a 32,768 Hz oscillator tick that is synchronous to it.
`ifndef BBCC_DEFINES_VH
`define BBCC_DEFINES_VH

// Memory map
`define BBCC_ADDR_W 17
`define BBCC_REG_BASE 17'h1_FFF8
`define BBCC_OFS_CTRL 17'h1_FFF8
`define BBCC_OFS_SEC 17'h1_FFF9
`define BBCC_OFS_MIN 17'h1_FFFA
`define BBCC_OFS_HOUR 17'h1_FFFB
`define BBCC_OFS_DAY 17'h1_FFFC
`define BBCC_OFS_DATE 17'h1_FFFD
`define BBCC_OFS_MONTH 17'h1_FFFE
`define BBCC_OFS_YEAR 17'h1_FFFF

// Register indexes inside the eight-byte block
`define BBCC_IDX_CTRL 3'h0
`define BBCC_IDX_SEC 3'h1
`define BBCC_IDX_MIN 3'h2
`define BBCC_IDX_HOUR 3'h3
`define BBCC_IDX_DAY 3'h4
`define BBCC_IDX_DATE 3'h5
`define BBCC_IDX_MONTH 3'h6
`define BBCC_IDX_YEAR 3'h7

// Field positions
`define BBCC_CTRL_WHALT_BIT 7
`define BBCC_CTRL_RHALT_BIT 6
`define BBCC_CTRL_SIGN_BIT 5
`define BBCC_OSC_STOP_BIT 7
`define BBCC_FREQ_TEST_BIT 6

// Reset values: oscillator stopped as shipped
`define BBCC_RST_CTRL 8'h00
`define BBCC_RST_SEC 8'h80
`define BBCC_RST_MIN 8'h00
`define BBCC_RST_HOUR 8'h00
`define BBCC_RST_DAY 8'h01
`define BBCC_RST_DATE 8'h01
`define BBCC_RST_MONTH 8'h01
`define BBCC_RST_YEAR 8'h00

// Divider and calibration
`define BBCC_OSC_HZ 32768
`define BBCC_PRE_DIV 128
`define BBCC_UNITS_PER_SEC 9'h100
`define BBCC_UNITS_FAST 9'h0FF
`define BBCC_UNITS_SLOW 9'h102

// Timing
`define BBCC_CLK_HZ 20000000
`define BBCC_REC_MS 40
`define BBCC_REC_CYCLES 24'h0C_3500
`define BBCC_OSC_START_S 1
`define BBCC_OSC_START_CYCLES 25'h131_2D00

`endif

// [design/bbcc_bcd_field.v]
// One BCD time field: increments on a step and wraps from its top value to its bottom value.
// Assumes the field already holds a legal BCD value.
`timescale 1ns/1ns
`default_nettype none

module bbcc_bcd_field #(
   parameter [7:0] LO = 8'h00
) (
   // Field value and step
   input wire [7:0] value,
   input wire step,
   input wire [7:0] hi,
   // Result
   output reg [7:0] nxt,
   output reg wrap
);

   always @* begin
      nxt = value;
      wrap = 1'b0;
      if (step) begin
         if (value >= hi) begin
            nxt = LO;
            wrap = 1'b1;
         end else if (value[3:0] == 4'h9) begin
            nxt = {value[7:4] + 4'h1, 4'h0};
         end else begin
            nxt = {value[7:4], value[3:0] + 4'h1};
         end
      end
   end

endmodule // bbcc_bcd_field

`default_nettype wire

// [design/bbcc_calendar_clock.v]
// Battery backed calendar clock with its byte-wide static memory and power-fail control.
// Assumes bus and supply-monitor inputs synchronous to clk and a one-cycle osc_tick at 32,768 Hz.
`timescale 1ns/1ns
`default_nettype none
`include "bbcc_defines.vh"

module bbcc_calendar_clock #(
   parameter [23:0] REC_CYCLES = `BBCC_REC_CYCLES,
   parameter [24:0] OSC_START_CYCLES = `BBCC_OSC_START_CYCLES
) (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Memory bus
   input wire [16:0] addr,
   input wire ce_n,
   input wire oe_n,
   input wire we_n,
   input wire [7:0] data_in,
   output reg [7:0] data_out,
   output reg data_oe_n,
   // Oscillator and supply monitors
   input wire osc_tick,
   input wire vcc_above_pfd,
   input wire vcc_above_so,
   output reg deselected,
   output reg on_battery
);

   // Memory and holding registers
   reg [7:0] mem [0:131071];
   reg [7:0] hold_r [0:7];

   // Running counters
   reg [7:0] cnt_sec_r;
   reg [7:0] cnt_min_r;
   reg [7:0] cnt_hour_r;
   reg [7:0] cnt_day_r;
   reg [7:0] cnt_date_r;
   reg [7:0] cnt_month_r;
   reg [7:0] cnt_year_r;

   // Divider, calibration and oscillator control
   reg [6:0] pre_r;
   reg [8:0] frac_r;
   reg [5:0] cal_min_r;
   reg osc_run_r;
   reg [24:0] osc_wait_r;
   reg whalt_d_r;

   // Power and bus state
   reg [23:0] rec_cnt_r;
   reg wr_act_r;
   reg [16:0] wr_addr_r;
   reg [7:0] wr_data_r;

   wire [7:0] ctrl = hold_r[`BBCC_IDX_CTRL];
   wire whalt = ctrl[`BBCC_CTRL_WHALT_BIT];
   wire rhalt = ctrl[`BBCC_CTRL_RHALT_BIT];
   wire osc_stop = hold_r[`BBCC_IDX_SEC][`BBCC_OSC_STOP_BIT];
   wire halted = whalt | rhalt;
   wire load_cnt = whalt_d_r & ~whalt;
   wire in_regs = (addr >= `BBCC_REG_BASE);
   wire wr_now = ~ce_n & ~we_n & ~deselected;
   wire wr_commit = wr_act_r & ~wr_now & vcc_above_pfd & ~deselected;
   wire wr_regs = wr_commit & (wr_addr_r >= `BBCC_REG_BASE);
   wire [2:0] wr_idx = wr_addr_r[2:0];

   // Divider path
   wire tick = osc_tick & osc_run_r;
   wire unit = tick & (pre_r == 7'h7F);
   wire [5:0] cal_span = {ctrl[4:0], 1'b0};
   wire cal_this = (cnt_sec_r == 8'h00) & (cal_min_r < cal_span);
   reg [8:0] sec_len;
   wire sec_tick = unit & (frac_r == sec_len - 9'h001);

   always @* begin
      sec_len = `BBCC_UNITS_PER_SEC;
      if (cal_this) begin
         if (ctrl[`BBCC_CTRL_SIGN_BIT]) begin
            sec_len = `BBCC_UNITS_FAST;
         end else begin
            sec_len = `BBCC_UNITS_SLOW;
         end
      end
   end

   // Last date of the current month, leap years every fourth year
   wire yr_tens_odd = cnt_year_r[4];
   wire [3:0] yr_ones = cnt_year_r[3:0];
   wire leap = yr_tens_odd ? (yr_ones == 4'h2 || yr_ones == 4'h6) :
      (yr_ones == 4'h0 || yr_ones == 4'h4 || yr_ones == 4'h8);
   reg [7:0] date_hi;

   always @* begin
      case (cnt_month_r)
         8'h02: date_hi = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: date_hi = 8'h30;
         default: date_hi = 8'h31;
      endcase
   end

   // Calendar carry chain
   wire [7:0] sec_nxt;
   wire [7:0] min_nxt;
   wire [7:0] hour_nxt;
   wire [7:0] day_nxt;
   wire [7:0] date_nxt;
   wire [7:0] month_nxt;
   wire [7:0] year_nxt;
   wire sec_wrap;
   wire min_wrap;
   wire hour_wrap;
   wire date_wrap;
   wire month_wrap;

   bbcc_bcd_field #(.LO(8'h00)) u_sec (
      .value(cnt_sec_r), .step(sec_tick), .hi(8'h59), .nxt(sec_nxt), .wrap(sec_wrap)
   );
   bbcc_bcd_field #(.LO(8'h00)) u_min (
      .value(cnt_min_r), .step(sec_wrap), .hi(8'h59), .nxt(min_nxt), .wrap(min_wrap)
   );
   bbcc_bcd_field #(.LO(8'h00)) u_hour (
      .value(cnt_hour_r), .step(min_wrap), .hi(8'h23), .nxt(hour_nxt), .wrap(hour_wrap)
   );
   bbcc_bcd_field #(.LO(8'h01)) u_day (
      .value(cnt_day_r), .step(hour_wrap), .hi(8'h07), .nxt(day_nxt), .wrap()
   );
   bbcc_bcd_field #(.LO(8'h01)) u_date (
      .value(cnt_date_r), .step(hour_wrap), .hi(date_hi), .nxt(date_nxt), .wrap(date_wrap)
   );
   bbcc_bcd_field #(.LO(8'h01)) u_month (
      .value(cnt_month_r), .step(date_wrap), .hi(8'h12), .nxt(month_nxt), .wrap(month_wrap)
   );
   bbcc_bcd_field #(.LO(8'h00)) u_year (
      .value(cnt_year_r), .step(month_wrap), .hi(8'h99), .nxt(year_nxt), .wrap()
   );

   // Power-fail deselect, recovery delay and battery switchover
   always @(posedge clk) begin
      if (!resetn) begin
         deselected <= 1'b1;
         rec_cnt_r <= 24'h00_0000;
         on_battery <= 1'b0;
      end else begin
         on_battery <= ~vcc_above_so;
         if (!vcc_above_pfd) begin
            deselected <= 1'b1;
            rec_cnt_r <= 24'h00_0000;
         end else if (deselected) begin
            // Stays out for the whole delay so the host sees no half-recovered bus
            if (rec_cnt_r >= REC_CYCLES - 24'h00_0001) begin
               deselected <= 1'b0;
            end else begin
               rec_cnt_r <= rec_cnt_r + 24'h00_0001;
            end
         end
      end
   end

   // Write capture: commit only at the end of the strobe
   always @(posedge clk) begin
      if (!resetn) begin
         wr_act_r <= 1'b0;
         wr_addr_r <= 17'h0_0000;
         wr_data_r <= 8'h00;
      end else if (deselected || !vcc_above_pfd) begin
         wr_act_r <= 1'b0;
      end else begin
         wr_act_r <= wr_now;
         if (wr_now) begin
            wr_addr_r <= addr;
            wr_data_r <= data_in;
         end
      end
   end

   // Ordinary memory bytes; a write lost to power failure leaves the array untouched
   always @(posedge clk) begin
      if (wr_commit && !wr_regs) begin
         mem[wr_addr_r] <= wr_data_r;
      end
   end

   // Read path
   always @(posedge clk) begin
      if (!resetn) begin
         data_out <= 8'h00;
         data_oe_n <= 1'b1;
      end else if (deselected || ce_n || oe_n || !we_n) begin
         data_oe_n <= 1'b1;
      end else begin
         data_oe_n <= 1'b0;
         if (in_regs) begin
            data_out <= hold_r[addr[2:0]];
         end else begin
            data_out <= mem[addr];
         end
      end
   end

   // Oscillator stop and restart delay
   always @(posedge clk) begin
      if (!resetn) begin
         osc_run_r <= 1'b0;
         osc_wait_r <= 25'h000_0000;
      end else if (osc_stop) begin
         osc_run_r <= 1'b0;
         osc_wait_r <= 25'h000_0000;
      end else if (!osc_run_r) begin
         if (osc_wait_r >= OSC_START_CYCLES - 25'h000_0001) begin
            osc_run_r <= 1'b1;
         end else begin
            osc_wait_r <= osc_wait_r + 25'h000_0001;
         end
      end
   end

   // Divider with calibration at the divide-by-256 stage
   always @(posedge clk) begin
      if (!resetn) begin
         pre_r <= 7'h00;
         frac_r <= 9'h000;
         cal_min_r <= 6'h00;
      end else if (load_cnt) begin
         pre_r <= 7'h00;
         frac_r <= 9'h000;
      end else begin
         if (tick) begin
            pre_r <= pre_r + 7'h01;
         end
         if (sec_tick) begin
            frac_r <= 9'h000;
         end else if (unit) begin
            frac_r <= frac_r + 9'h001;
         end
         if (sec_wrap) begin
            cal_min_r <= cal_min_r + 6'h01;
         end
      end
   end

   // Running counters; never stopped by a halt
   always @(posedge clk) begin
      if (!resetn) begin
         cnt_sec_r <= `BBCC_RST_SEC & 8'h7F;
         cnt_min_r <= `BBCC_RST_MIN;
         cnt_hour_r <= `BBCC_RST_HOUR;
         cnt_day_r <= `BBCC_RST_DAY;
         cnt_date_r <= `BBCC_RST_DATE;
         cnt_month_r <= `BBCC_RST_MONTH;
         cnt_year_r <= `BBCC_RST_YEAR;
      end else if (load_cnt) begin
         cnt_sec_r <= hold_r[`BBCC_IDX_SEC] & 8'h7F;
         cnt_min_r <= hold_r[`BBCC_IDX_MIN] & 8'h7F;
         cnt_hour_r <= hold_r[`BBCC_IDX_HOUR] & 8'h3F;
         cnt_day_r <= hold_r[`BBCC_IDX_DAY] & 8'h07;
         cnt_date_r <= hold_r[`BBCC_IDX_DATE] & 8'h3F;
         cnt_month_r <= hold_r[`BBCC_IDX_MONTH] & 8'h1F;
         cnt_year_r <= hold_r[`BBCC_IDX_YEAR];
      end else begin
         cnt_sec_r <= sec_nxt;
         cnt_min_r <= min_nxt;
         cnt_hour_r <= hour_nxt;
         cnt_day_r <= day_nxt;
         cnt_date_r <= date_nxt;
         cnt_month_r <= month_nxt;
         cnt_year_r <= year_nxt;
      end
   end

   // Holding registers: host writes, then a whole-snapshot refresh when not halted
   always @(posedge clk) begin
      if (!resetn) begin
         hold_r[`BBCC_IDX_CTRL] <= `BBCC_RST_CTRL;
         hold_r[`BBCC_IDX_SEC] <= `BBCC_RST_SEC;
         hold_r[`BBCC_IDX_MIN] <= `BBCC_RST_MIN;
         hold_r[`BBCC_IDX_HOUR] <= `BBCC_RST_HOUR;
         hold_r[`BBCC_IDX_DAY] <= `BBCC_RST_DAY;
         hold_r[`BBCC_IDX_DATE] <= `BBCC_RST_DATE;
         hold_r[`BBCC_IDX_MONTH] <= `BBCC_RST_MONTH;
         hold_r[`BBCC_IDX_YEAR] <= `BBCC_RST_YEAR;
         whalt_d_r <= 1'b0;
      end else begin
         whalt_d_r <= whalt;
         if (wr_regs) begin
            hold_r[wr_idx] <= wr_data_r;
         end
         // One-cycle copy of every field, so a snapshot is never torn
         // Held off while counters load, so the old count never overwrites the new time
         if (!halted && !load_cnt && !(wr_regs && wr_idx == `BBCC_IDX_CTRL)) begin
            hold_r[`BBCC_IDX_SEC][6:0] <= cnt_sec_r[6:0];
            hold_r[`BBCC_IDX_MIN] <= cnt_min_r;
            hold_r[`BBCC_IDX_HOUR] <= cnt_hour_r;
            hold_r[`BBCC_IDX_DAY][2:0] <= cnt_day_r[2:0];
            hold_r[`BBCC_IDX_DATE] <= cnt_date_r;
            hold_r[`BBCC_IDX_MONTH] <= cnt_month_r;
            hold_r[`BBCC_IDX_YEAR] <= cnt_year_r;
         end
      end
   end

endmodule // bbcc_calendar_clock

`default_nettype wire

// [sim/bbcc_properties.sv]
// Concurrent checks on the calendar clock ports: power-fail deselect, bus drive, battery flag.
// Assumes the bench runs REC_CYCLES well above two and drives inputs at the falling edge.
`timescale 1ns/1ns
`default_nettype none
module bbcc_properties #(
   parameter [23:0] REC_CYCLES = 24'h00_0014
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Memory bus
   input wire logic [16:0] addr,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic data_oe_n,
   // Oscillator and supply monitors
   input wire logic osc_tick,
   input wire logic vcc_above_pfd,
   input wire logic vcc_above_so,
   input wire logic deselected,
   input wire logic on_battery
);
   reg [23:0] rec_r;
   wire rd_w = !ce_n && !oe_n && we_n && !deselected;
   // Counts good-supply cycles spent deselected; a tolerance of two absorbs register stages
   always @(posedge clk) begin
      if (!resetn || !vcc_above_pfd || !deselected) begin
         rec_r <= 24'h00_0000;
      end else begin
         rec_r <= rec_r + 24'h00_0001;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   a_fail_deselects: assert property (!vcc_above_pfd |=> deselected)
      else $error("no deselect after supply fail");
   a_desel_float: assert property (deselected |=> data_oe_n)
      else $error("data driven while deselected");
   a_desel_quiet: assert property (deselected |=> $stable(data_out))
      else $error("read data changed while deselected");
   a_read_drives: assert property (rd_w |=> !data_oe_n)
      else $error("read not answered");
   a_idle_floats: assert property ((ce_n || oe_n || !we_n) |=> data_oe_n)
      else $error("data driven outside a read");
   a_battery_follow: assert property (1'b1 |=> on_battery == !$past(vcc_above_so))
      else $error("battery flag does not follow switchover");
   a_rec_min: assert property ($fell(deselected) |-> rec_r >= REC_CYCLES - 24'h00_0002)
      else $error("recovery delay too short");
   a_rec_max: assert property (deselected |-> rec_r <= REC_CYCLES + 24'h00_0002)
      else $error("recovery delay too long");
   a_mem_stable: assert property ((rd_w && addr < 17'h1_FFF8) ##1 (rd_w && $stable(addr))
      |=> $stable(data_out))
      else $error("memory read data unstable");
endmodule // bbcc_properties
bind bbcc_calendar_clock bbcc_properties #(.REC_CYCLES(REC_CYCLES)) chk_u (
   .clk(clk), .resetn(resetn), .addr(addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
   .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .osc_tick(osc_tick),
   .vcc_above_pfd(vcc_above_pfd), .vcc_above_so(vcc_above_so), .deselected(deselected),
   .on_battery(on_battery));
`default_nettype wire

// [sim/bbcc_host_model.sv]
// Host processor on the asynchronous byte bus, with read and write tasks.
// Assumes the block samples the bus on rising edges; this model moves it on falling edges.
`timescale 1ns/1ns
`default_nettype none
module bbcc_host_model (
   // Clock
   input wire logic clk,
   // Bus to the block
   output logic [16:0] addr,
   output logic ce_n,
   output logic oe_n,
   output logic we_n,
   output logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic data_oe_n
);
   initial begin
      addr = 17'h0_0000;
      ce_n = 1'b1;
      oe_n = 1'b1;
      we_n = 1'b1;
      data_in = 8'h00;
   end
   // Strobe pair held low over two edges so a supply drop can land inside the write
   task automatic wr(input logic [16:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      data_in = d;
      ce_n = 1'b0;
      we_n = 1'b0;
      repeat (2) @(negedge clk);
      ce_n = 1'b1;
      we_n = 1'b1;
      @(negedge clk);
      data_in = ~d;
   endtask
   task automatic rd(input logic [16:0] a, output logic [7:0] d, output logic z);
      @(negedge clk);
      addr = a;
      ce_n = 1'b0;
      oe_n = 1'b0;
      repeat (2) @(negedge clk);
      d = data_out;
      z = data_oe_n;
      ce_n = 1'b1;
      oe_n = 1'b1;
   endtask
endmodule // bbcc_host_model
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the calendar clock: registers, memory, power fail and halts.
// Assumes short recovery and start counts; an oscillator tick every clock keeps runs short.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic resetn, osc_tick, vcc_above_pfd, vcc_above_so;
   logic [16:0] addr;
   logic ce_n, oe_n, we_n, data_oe_n, deselected, on_battery, rz;
   logic [7:0] data_in, data_out, rv;
   logic [7:0] rst_v [8] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
   logic [7:0] set_v [8] = '{8'h00, 8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
   logic [7:0] roll_v [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
   int error_cnt = 0;
   int n_tests = 0;
   int i;
   always #25 clk = ~clk;
   bbcc_calendar_clock #(.REC_CYCLES(24'h00_0014), .OSC_START_CYCLES(25'h000_000A)) dut_u (
      .clk(clk), .resetn(resetn), .addr(addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .osc_tick(osc_tick),
      .vcc_above_pfd(vcc_above_pfd), .vcc_above_so(vcc_above_so), .deselected(deselected),
      .on_battery(on_battery));
   bbcc_host_model host_u (.clk(clk), .addr(addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic rchk(input logic [16:0] a, input logic [7:0] exp);
      host_u.rd(a, rv, rz);
      chk("data_oe_n", {7'h00, rz}, 8'h00);
      chk("read data", rv, exp);
   endtask
   task automatic wait_up;
      for (int k = 0; k < 200 && deselected !== 1'b0; k++) @(negedge clk);
      chk("deselected", {7'h00, deselected}, 8'h00);
   endtask
   task automatic wrap_up;
      if (error_cnt == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (80000) @(posedge clk);
      error_cnt++;
      wrap_up();
   end
   initial begin
      resetn = 1'b0;
      osc_tick = 1'b1;
      vcc_above_pfd = 1'b1;
      vcc_above_so = 1'b1;
      repeat (5) @(negedge clk);
      resetn = 1'b1;
      wait_up();
      for (i = 0; i < 8; i++) rchk({14'h3FFF, i[2:0]}, rst_v[i]);
      host_u.wr(17'h0_0005, 8'h11);
      host_u.wr(17'h1_FFF7, 8'h5A);
      rchk(17'h0_0005, 8'h11);
      rchk(17'h1_FFF7, 8'h5A);
      fork
         host_u.wr(17'h0_0005, 8'hAA);
         begin
            repeat (2) @(negedge clk);
            vcc_above_pfd = 1'b0;
         end
      join
      chk("deselected", {7'h00, deselected}, 8'h01);
      host_u.wr(17'h0_0005, 8'h77);
      host_u.rd(17'h0_0005, rv, rz);
      chk("data_oe_n", {7'h00, rz}, 8'h01);
      vcc_above_so = 1'b0;
      repeat (2) @(negedge clk);
      chk("on_battery", {7'h00, on_battery}, 8'h01);
      vcc_above_so = 1'b1;
      vcc_above_pfd = 1'b1;
      repeat (2) @(negedge clk);
      chk("on_battery", {7'h00, on_battery}, 8'h00);
      chk("deselected", {7'h00, deselected}, 8'h01);
      wait_up();
      rchk(17'h0_0005, 8'h11);
      rchk(17'h1_FFF7, 8'h5A);
      host_u.wr(17'h1_FFF8, 8'h80);
      for (i = 1; i < 8; i++) host_u.wr({14'h3FFF, i[2:0]}, set_v[i]);
      host_u.wr(17'h1_FFF8, 8'h00);
      rchk(17'h1_FFF9, 8'h59);
      repeat (32000) @(negedge clk);
      rchk(17'h1_FFF9, 8'h59);
      repeat (1000) @(negedge clk);
      for (i = 1; i < 8; i++) rchk({14'h3FFF, i[2:0]}, roll_v[i]);
      // Read halt plus one positive step: second 00 ends one unit early, and the
      // first read after the halt lands inside that gap
      host_u.wr(17'h1_FFF8, 8'h61);
      repeat (32430) @(negedge clk);
      rchk(17'h1_FFF9, 8'h00);
      rchk(17'h1_FFFA, 8'h00);
      host_u.wr(17'h1_FFF8, 8'h21);
      rchk(17'h1_FFF9, 8'h01);
      repeat (20) @(negedge clk);
      rchk(17'h1_FFF9, 8'h01);
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
